// *** rtl/smb_pkg.sv ***
// Constants for the SDRAM mode register and burst address sequencer.
// Assumes a single 100 MHz device clock shared with the controller.
package smb_pkg;
    // ==========================================================
    // Mode field positions
    localparam int BL_LSB = 0;
    localparam int BL_MSB = 2;
    localparam int ORDER_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int LAT_MSB = 6;
    localparam int OPMODE_LO_BIT = 7;
    localparam int OPMODE_HI_BIT = 8;
    localparam int WB_MODE_BIT = 9;
    localparam int MODE_W = 12;
    localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
    // ==========================================================
    // Field encodings
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] LAT_2 = 3'h2;
    localparam logic [2:0] LAT_3 = 3'h3;
    // ==========================================================
    // Page sizes per data width
    localparam int PAGE_X4 = 2048;
    localparam int PAGE_X8 = 1024;
    localparam int PAGE_X16 = 512;
    // ==========================================================
    // Command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;
    localparam int NUM_BANKS = 4;
endpackage : smb_pkg

// *** rtl/smb_lat_pipe.sv ***
// Read latency shift pipe: delays a read strobe and its column by 1..DEPTH cycles.
// Assumes the tap is stable while a burst is in flight.
`timescale 1ns/1ps
`default_nettype none
module smb_lat_pipe #(
    parameter int DEPTH = 3,
    parameter int W = 11
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_vld,
    input wire logic [W-1:0] i_data,
    input wire logic [1:0] i_tap,
    output logic o_vld,
    output logic [W-1:0] o_data
);
    logic [DEPTH-1:0] vld_ff;
    logic [W-1:0] data_ff [DEPTH];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            vld_ff <= '0;
        end else begin
            vld_ff <= {vld_ff[DEPTH-2:0], i_vld};
        end
    end

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_stage
            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    data_ff[g] <= '0;
                end else begin
                    data_ff[g] <= (g == 0) ? i_data : data_ff[(g == 0) ? 0 : g-1];
                end
            end
        end
    endgenerate

    always_comb begin
        o_vld = vld_ff[i_tap];
        o_data = data_ff[i_tap];
    end
endmodule : smb_lat_pipe
`default_nettype wire

// *** rtl/smb_core.sv ***
// SDRAM mode register, burst column sequencer and activate tracking.
// Assumes commands are registered on i_clk with the controller obeying spacing rules.
// Summary of operation
// - Mode fields: length 2:0, order 3, latency 6:4, op mode 8:7, write mode 9.
// - Mode settings hold until the next mode load.
// - Lengths 1,2,4,8 in both orders; whole page only sequential.
// - Whole-page bursts run until stopped by the burst stop command.
// - Aligned block from upper column bits; low bits start and wrap inside.
// - Page is 2048, 1024 or 512 columns by data width.
// - Whole-page burst starts at full column and wraps to zero.
// - Sequential is start plus count; interleaved is start xor count.
// - Length one accesses only the addressed column, order ignored.
// - Read latency two or three cycles; other codes reserved.
// - Read at edge n drives after n+m-1, valid by n+m.
// - Write mode bit one makes writes single-column accesses.
// - Other banks may activate during access, spaced by bank gap.
`timescale 1ns/1ps
`default_nettype none
module smb_core
    import smb_pkg::*;
#(
    parameter int PAGE_COLS = PAGE_X4,
    parameter int COL_W = $clog2(PAGE_COLS),
    parameter int ROW_W = 12
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_cmd,
    input wire logic [ROW_W-1:0] i_addr,
    input wire logic i_bank_select_low,
    input wire logic i_bank_select_high,
    output logic [MODE_W-1:0] o_mode,
    output logic o_busy,
    output logic o_is_write,
    output logic [COL_W-1:0] o_col,
    output logic o_col_vld,
    output logic o_rd_drive,
    output logic o_rd_vld,
    output logic [COL_W-1:0] o_rd_col,
    output logic [NUM_BANKS-1:0] o_bank_open,
    output logic o_lat_reserved
);
    // ==========================================================
    // Command decode
    logic cmd_load, cmd_act, cmd_rd, cmd_wr, cmd_stop;
    logic [1:0] bank;
    always_comb begin
        cmd_load = (i_cmd == CMD_MODE_LOAD) && !i_bank_select_low && !i_bank_select_high;
        cmd_act = (i_cmd == CMD_ACTIVATE);
        cmd_rd = (i_cmd == CMD_READ);
        cmd_wr = (i_cmd == CMD_WRITE);
        cmd_stop = (i_cmd == CMD_BURST_STOP);
        bank = {i_bank_select_high, i_bank_select_low};
    end

    // ==========================================================
    // Mode register
    logic [MODE_W-1:0] mode_ff;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_ff <= MODE_RESET;
        end else if (cmd_load) begin
            mode_ff <= i_addr[MODE_W-1:0];
        end
    end
    assign o_mode = mode_ff;

    logic [2:0] bl_code, lat_code;
    logic seq_order, wb_single;
    always_comb begin
        bl_code = mode_ff[BL_MSB:BL_LSB];
        seq_order = !mode_ff[ORDER_BIT];
        lat_code = mode_ff[LAT_MSB:LAT_LSB];
        wb_single = mode_ff[WB_MODE_BIT];
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_lat_reserved <= 1'b0;
        end else begin
            o_lat_reserved <= (lat_code != LAT_2) && (lat_code != LAT_3);
        end
    end

    // ==========================================================
    // Burst sequencer
    logic busy_ff, is_wr_ff, page_ff, inter_ff;
    logic [3:0] len_ff;
    logic [2:0] cnt_ff;
    logic [2:0] start_ff;
    logic [COL_W-1:0] base_ff, col_ff;
    logic col_vld_ff;
    logic [3:0] nxt_len;
    logic nxt_page;
    logic [2:0] mask;

    always_comb begin
        nxt_page = 1'b0;
        case (bl_code)
            BL_1: nxt_len = 4'h1;
            BL_2: nxt_len = 4'h2;
            BL_4: nxt_len = 4'h4;
            BL_8: nxt_len = 4'h8;
            BL_PAGE: begin
                nxt_len = 4'h0;
                nxt_page = seq_order;
                if (!seq_order) begin
                    nxt_len = 4'h1;
                end
            end
            default: nxt_len = 4'h1;
        endcase
        if (cmd_wr && wb_single) begin
            nxt_len = 4'h1;
            nxt_page = 1'b0;
        end
        mask = 3'(nxt_len - 4'h1);
    end

    // Offset within block: sequential adds, interleaved xors
    logic [2:0] blk_mask, offs;
    always_comb begin
        blk_mask = 3'(len_ff - 4'h1);
        if (inter_ff) begin
            offs = (start_ff ^ cnt_ff) & blk_mask;
        end else begin
            offs = 3'(start_ff + cnt_ff) & blk_mask;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_ff <= 1'b0;
            is_wr_ff <= 1'b0;
            page_ff <= 1'b0;
            inter_ff <= 1'b0;
            len_ff <= 4'h1;
            cnt_ff <= 3'h0;
            start_ff <= 3'h0;
            base_ff <= '0;
            col_ff <= '0;
            col_vld_ff <= 1'b0;
        end else if (cmd_rd || cmd_wr) begin
            busy_ff <= nxt_page || (nxt_len > 4'h1);
            is_wr_ff <= cmd_wr;
            page_ff <= nxt_page;
            inter_ff <= !seq_order && (nxt_len > 4'h1);
            len_ff <= nxt_page ? 4'h1 : nxt_len;
            cnt_ff <= 3'h1;
            start_ff <= i_addr[2:0] & mask;
            base_ff <= i_addr[COL_W-1:0] & ~COL_W'(mask);
            col_ff <= i_addr[COL_W-1:0];
            col_vld_ff <= 1'b1;
        end else if (cmd_stop) begin
            busy_ff <= 1'b0;
            col_vld_ff <= 1'b0;
        end else if (busy_ff && page_ff) begin
            col_ff <= COL_W'(col_ff + 1'b1);
        end else if (busy_ff) begin
            col_ff <= base_ff | COL_W'(offs);
            cnt_ff <= 3'(cnt_ff + 3'h1);
            busy_ff <= (4'(cnt_ff) + 4'h1) < len_ff;
        end else begin
            col_vld_ff <= 1'b0;
        end
    end
    assign o_busy = busy_ff;
    assign o_is_write = is_wr_ff;
    assign o_col = col_ff;
    assign o_col_vld = col_vld_ff;

    // ==========================================================
    // Read latency: column appears at the pins lat cycles after the read
    logic rd_beat;
    logic [1:0] tap_vld;
    always_comb begin
        rd_beat = col_vld_ff && !is_wr_ff;
        tap_vld = (lat_code == LAT_3) ? 2'h1 : 2'h0;
    end
    // Latency three turns the pins on one beat later than latency two
    logic rd_beat_d_ff;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_beat_d_ff <= 1'b0;
        end else begin
            rd_beat_d_ff <= rd_beat;
        end
    end
    logic pipe_vld;
    logic [COL_W-1:0] pipe_col;
    smb_lat_pipe #(.DEPTH(3), .W(COL_W)) u_pipe (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_vld(rd_beat),
        .i_data(col_ff),
        .i_tap(tap_vld),
        .o_vld(pipe_vld),
        .o_data(pipe_col)
    );
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rd_vld <= 1'b0;
            o_rd_col <= '0;
            o_rd_drive <= 1'b0;
        end else begin
            o_rd_vld <= pipe_vld;
            o_rd_col <= pipe_col;
            o_rd_drive <= pipe_vld | ((lat_code == LAT_3) ? rd_beat_d_ff : rd_beat);
        end
    end

    // ==========================================================
    // Open-bank tracking; any bank may be activated while another is busy
    logic [NUM_BANKS-1:0] open_ff;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            open_ff <= '0;
        end else if (cmd_act) begin
            open_ff[bank] <= 1'b1;
        end
    end
    assign o_bank_open = open_ff;

    // ==========================================================
    // Checks

    // Mode register
    AST_MODE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !$past(cmd_load) |-> $stable(mode_ff))
        else $error("mode changed without load");
    AST_MODE_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cmd_load |=> mode_ff == $past(i_addr[MODE_W-1:0]))
        else $error("mode load lost");
    AST_LOAD_REFUSED: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_cmd == CMD_MODE_LOAD && (i_bank_select_low || i_bank_select_high)) |=> $stable(mode_ff))
        else $error("mode load to wrong target taken");
    AST_LAT_CODE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (lat_code == LAT_2 || lat_code == LAT_3) |=> !o_lat_reserved)
        else $error("legal latency flagged");

    // Burst column order
    AST_SEQ_START: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (cmd_rd || cmd_wr) |=> col_vld_ff && col_ff == $past(i_addr[COL_W-1:0]))
        else $error("first beat not the addressed column");
    AST_BL1_EXACT: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (cmd_rd && bl_code == BL_1) |=> !busy_ff && col_ff == $past(i_addr[COL_W-1:0]))
        else $error("single access wrong");
    AST_WB_SINGLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (cmd_wr && wb_single) |=> !busy_ff)
        else $error("write burst not single");
    AST_BURST_END: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (busy_ff && !page_ff && cnt_ff == 3'(len_ff - 4'h1) && !cmd_rd && !cmd_wr && !cmd_stop)
        |=> !busy_ff)
        else $error("fixed burst overran");
    AST_BLOCK_STAY: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (busy_ff && !page_ff && !cmd_rd && !cmd_wr && !cmd_stop)
        |=> (col_ff & ~COL_W'(blk_mask)) == base_ff)
        else $error("burst left block");
    AST_PAGE_SEQ_ONLY: assert property (@(posedge i_clk) disable iff (!i_rstn)
        page_ff |-> !inter_ff)
        else $error("interleaved page burst");
    AST_PAGE_STEP: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (busy_ff && page_ff && !cmd_rd && !cmd_wr && !cmd_stop) |=> col_ff == COL_W'($past(col_ff) + 1'b1))
        else $error("page step wrong");
    AST_PAGE_WRAP: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (busy_ff && page_ff && col_ff == COL_W'(PAGE_COLS-1) && !cmd_rd && !cmd_wr && !cmd_stop)
        |=> col_ff == '0)
        else $error("page wrap wrong");
    AST_STOP: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cmd_stop |=> !busy_ff)
        else $error("stop ignored");

    // Read timing; a mode load while a read drains would move the tap
    AST_CL2: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (cmd_rd && lat_code == LAT_2 && !cmd_load) |-> ##3 o_rd_vld)
        else $error("latency two wrong");
    AST_CL3: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (cmd_rd && lat_code == LAT_3) |-> ##4 o_rd_vld)
        else $error("latency three wrong");
    AST_RD_DRIVE_LEAD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(o_rd_vld) |-> $past(o_rd_drive))
        else $error("pins not driven ahead of data");
    AST_RD_DRIVE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_rd_vld |-> o_rd_drive)
        else $error("pins released under valid data");

    // Bank tracking
    AST_BANK_OPEN: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cmd_act |=> open_ff[$past(bank)])
        else $error("activated bank not marked open");

    // Main scenarios
    COV_PAGE: cover property (@(posedge i_clk) busy_ff && page_ff);
    COV_INTER8: cover property (@(posedge i_clk) inter_ff && len_ff == 4'h8);
    COV_STOP: cover property (@(posedge i_clk) busy_ff ##1 cmd_stop);
    COV_CL3: cover property (@(posedge i_clk) o_rd_vld && lat_code == LAT_3);
    COV_WB_WRITE: cover property (@(posedge i_clk) cmd_wr && wb_single);
endmodule : smb_core
`default_nettype wire

// *** bench/smb_ctl_model.sv ***
// Controller model: issues commands to the mode and burst core.
// Assumes the core samples commands on the rising edge of i_clk.
`timescale 1ns/1ps
`default_nettype none
module smb_ctl_model
    import smb_pkg::*;
#(
    parameter int MRD_CYC = 2,
    parameter int RRD_CYC = 2
) (
    input wire logic i_clk,
    output logic [3:0] o_cmd,
    output logic [11:0] o_addr,
    output logic o_bank_select_low,
    output logic o_bank_select_high
);
    // ==========================================================
    // Command issue
    localparam logic [3:0] CMD_NOP = 4'h7;
    initial begin
        o_cmd = CMD_NOP;
        o_addr = 12'h000;
        o_bank_select_low = 1'b0;
        o_bank_select_high = 1'b0;
    end
    // Released address and bank lines show the inverse so stale values never look valid; the command returns to NOP
    task automatic send(input logic [3:0] cmd, input logic [11:0] addr, input logic [1:0] bank);
        @(negedge i_clk);
        o_cmd = cmd;
        o_addr = addr;
        {o_bank_select_high, o_bank_select_low} = bank;
        @(negedge i_clk);
        o_cmd = CMD_NOP;
        o_addr = ~addr;
        {o_bank_select_high, o_bank_select_low} = ~bank;
    endtask
    task automatic load_mode(input logic [11:0] m);
        send(CMD_MODE_LOAD, m & 12'h3FF, 2'b00);
        repeat (MRD_CYC) @(negedge i_clk);
    endtask
    // Each bank opened once; RRD_CYC spacing kept by the task after the send
    task automatic activate(input logic [11:0] row, input logic [1:0] bank);
        send(CMD_ACTIVATE, row, bank);
        repeat (RRD_CYC) @(negedge i_clk);
    endtask
endmodule // smb_ctl_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the mode register and burst sequencer.
// Assumes the x16 page size so columns are address bits 8:0.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
    import smb_pkg::*;
    // ==========================================================
    // Signals and instances
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [3:0] cmd;
    logic [11:0] addr;
    logic bs_lo;
    logic bs_hi;
    logic [MODE_W-1:0] mode;
    logic busy;
    logic is_wr;
    logic col_vld;
    logic rd_drive;
    logic rd_vld;
    logic lat_res;
    logic [8:0] col;
    logic [8:0] rd_col;
    logic [3:0] bank_open;
    int bad_count = 0;
    int samples_checked = 0;
    always #5 i_clk = ~i_clk;
    smb_ctl_model ctl (.i_clk(i_clk), .o_cmd(cmd), .o_addr(addr), .o_bank_select_low(bs_lo),
        .o_bank_select_high(bs_hi));
    smb_core #(.PAGE_COLS(PAGE_X16)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cmd(cmd), .i_addr(addr),
        .i_bank_select_low(bs_lo), .i_bank_select_high(bs_hi), .o_mode(mode), .o_busy(busy),
        .o_is_write(is_wr), .o_col(col), .o_col_vld(col_vld), .o_rd_drive(rd_drive), .o_rd_vld(rd_vld),
        .o_rd_col(rd_col), .o_bank_open(bank_open), .o_lat_reserved(lat_res));
    // ==========================================================
    // Helpers
    task automatic close_out();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic [11:0] mword(input logic [2:0] bl, input logic ilv, input logic [2:0] lat,
        input logic wb);
        return {2'b00, wb, 2'b00, lat, ilv, bl};
    endfunction
    // Page bursts wrap at 512, which the 9-bit sum does for free
    function automatic logic [8:0] exp_col(input logic [8:0] s, input int len, input logic ilv, input int k);
        logic [8:0] m;
        m = 9'(len - 1);
        if (len > 8) begin
            return s + 9'(k);
        end
        return (s & ~m) | (ilv ? ((s ^ 9'(k)) & m) : ((s + 9'(k)) & m));
    endfunction
    task automatic burst(input logic [3:0] c, input logic [8:0] s, input int len, input logic ilv,
        input int n, input logic wr);
        int w;
        w = 0;
        ctl.send(c, {3'b000, s}, 2'b00);
        while (col_vld !== 1'b1 && w < 4) begin
            @(negedge i_clk);
            w++;
        end
        if (w == 4) begin
            bad_count++;
            close_out();
        end
        `CHK(is_wr, wr)
        for (int k = 0; k < n; k++) begin
            `CHK(col_vld, 1'b1)
            `CHK(col, exp_col(s, len, ilv, k))
            @(negedge i_clk);
        end
        if (len <= 8) begin
            `CHK(col_vld, 1'b0)
        end
    endtask
    // Counts falling edges from the send; valid is registered CL edges after the command,
    // and the pins turn on one edge before that
    task automatic rd_lat(input logic [8:0] s, input int cl);
        int n;
        int d;
        n = 1;
        d = 0;
        repeat (6) @(negedge i_clk);
        ctl.send(CMD_READ, {3'b000, s}, 2'b00);
        while (rd_vld !== 1'b1 && n < 8) begin
            if (rd_drive === 1'b1 && d == 0) begin
                d = n;
            end
            @(negedge i_clk);
            n++;
        end
        `CHK(n, cl + 1)
        `CHK(d, cl)
        `CHK(rd_col, s)
        `CHK(rd_drive, 1'b1)
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        close_out();
    end
    initial begin
        repeat (10) @(negedge i_clk);
        i_rstn = 1'b1;
        `CHK(mode, MODE_RESET)
        `CHK(bank_open, 4'h0)
        ctl.send(CMD_MODE_LOAD, mword(BL_4, 1'b0, LAT_2, 1'b0), 2'b01);
        `CHK(mode, MODE_RESET)
        ctl.activate(12'h123, 2'b00);
        ctl.activate(12'h0F0, 2'b11);
        `CHK(bank_open, 4'h9)
        for (int i = 0; i < 3; i++) begin
            for (int t = 0; t < 2; t++) begin
                ctl.load_mode(mword(3'(i + 1), t[0], LAT_2, 1'b0));
                `CHK(mode, mword(3'(i + 1), t[0], LAT_2, 1'b0))
                burst(CMD_READ, 9'h0B5, 2 << i, t[0], 2 << i, 1'b0);
            end
        end
        ctl.load_mode(mword(BL_1, 1'b1, LAT_3, 1'b0));
        burst(CMD_READ, 9'h0B5, 1, 1'b1, 1, 1'b0);
        rd_lat(9'h013, 3);
        ctl.load_mode(mword(BL_1, 1'b0, 3'h5, 1'b0));
        `CHK(lat_res, 1'b1)
        ctl.load_mode(mword(BL_1, 1'b0, LAT_2, 1'b0));
        `CHK(lat_res, 1'b0)
        rd_lat(9'h1A0, 2);
        ctl.load_mode(mword(BL_4, 1'b0, LAT_2, 1'b1));
        burst(CMD_WRITE, 9'h0B5, 1, 1'b0, 1, 1'b1);
        burst(CMD_READ, 9'h0B5, 4, 1'b0, 4, 1'b0);
        ctl.load_mode(mword(BL_4, 1'b0, LAT_2, 1'b0));
        burst(CMD_WRITE, 9'h0B6, 4, 1'b0, 4, 1'b1);
        ctl.load_mode(mword(BL_PAGE, 1'b0, LAT_2, 1'b0));
        burst(CMD_READ, 9'h1FE, 512, 1'b0, 4, 1'b0);
        ctl.send(CMD_BURST_STOP, 12'h000, 2'b00);
        repeat (2) @(negedge i_clk);
        `CHK(busy, 1'b0)
        `CHK(col_vld, 1'b0)
        `CHK(mode, mword(BL_PAGE, 1'b0, LAT_2, 1'b0))
        close_out();
    end
endmodule // tb_top
`undef CHK
`default_nettype wire
